// >>> core/dcw_defines.svh
// Purpose: Constants for the debug command and watchpoint block
// Assumes: Byte-wide link and 8-bit register file data
// Notes:   Register offsets are byte addresses on the register bus
`ifndef DCW_DEFINES_SVH
`define DCW_DEFINES_SVH
`define DCW_CMD_RDMEM   8'h0D
`define DCW_CMD_CRC     8'h0E
`define DCW_CMD_STEP    8'h10
`define DCW_CMD_STUFF   8'h11
`define DCW_CMD_EXEC    8'h12
`define DCW_BLANK_BYTE  8'hFF
`define DCW_CNT_FULL    17'h10000
`define DCW_CRC_INIT    16'hFFFF
`define DCW_CRC_POLY    16'h1021
`define DCW_WPW_BIT     7
`define DCW_WPR_BIT     6
`define DCW_WATCH_DATA_MATCH_BIT    5
`define DCW_PROT_MASK   8'h1F
`define DCW_WCTL_RST    8'h00
`define DCW_OFS_WCTL    8'h00
`define DCW_OFS_WADDR   8'h04
`define DCW_OFS_WDATA   8'h08
`define DCW_OFS_STATUS  8'h0C
`define DCW_OFS_IRQ     8'h10
`define DCW_OFS_MASK    8'h14
`define DCW_IRQ_BRK     0
`define DCW_IRQ_CRC     1
`define DCW_IRQ_IGN     2
`define DCW_RESP_OK     2'h0
`define DCW_RESP_ERR    2'h2
`endif

// >>> core/dcw_pkg.sv
// Purpose: Types for the debug command and watchpoint block
// Assumes: Constants come from dcw_defines.svh
// Notes:   Types only
package dcw_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR_HI, S_ADDR_LO, S_CNT_HI, S_CNT_LO, S_RD_REQ, S_RD_SEND,
    S_CRC_REQ, S_CRC_FIN, S_CRC_HI, S_CRC_LO, S_STUFF, S_EXEC_FIRST,
    S_EXEC_LEN, S_EXEC_REST, S_EXEC_DISCARD
  } dcw_fsm_t;

  typedef struct packed {
    logic       step;
    logic       stuff;
    logic       valid;
    logic [7:0] byte_v;
  } dcw_cpu_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  data;
  } dcw_rf_t;

  typedef struct packed {
    dcw_fsm_t   fsm;
    logic       dbg_ok;
    logic       run_ok;
    logic [15:0] addr;
    logic [16:0] cnt;
    logic [2:0] left;
    logic [7:0] tx_byte;
    logic       tx_valid;
    dcw_cpu_t   cpu;
    logic [7:0] wctl;
    logic [7:0] waddr;
    logic [7:0] wdat;
    logic [2:0] irq;
    logic [2:0] mask;
    logic       aw_got;
    logic [7:0] awa;
    logic       w_got;
    logic [7:0] wd;
    logic       wst;
    logic       bvalid;
    logic       berr;
    logic       rvalid;
    logic       rerr;
    logic [7:0] rdata;
  } dcw_state_t;

  typedef struct packed {
    logic brk;
  } dcw_wst_t;

  typedef struct packed {
    logic [15:0] crc;
  } dcw_cst_t;
endpackage : dcw_pkg

// >>> core/dcw_crc.sv
// Purpose: CRC-CCITT accumulator over program memory bytes
// Assumes: One byte per feed, most significant bit first
// Notes:   Init has priority over feed
`timescale 1ns/1ps
`include "dcw_defines.svh"
module dcw_crc
  import dcw_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        init,
  input  wire logic        feed,
  input  wire logic [7:0]  byte_in,
  output logic      [15:0] crc
);
  dcw_cst_t st;
  dcw_cst_t nx;

  always_comb
  begin
    logic [15:0] c;
    logic        fb;
    c  = st.crc;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      fb = c[15] ^ byte_in[i];
      c  = {c[14:0], 1'b0} ^ (fb ? `DCW_CRC_POLY : 16'h0000);
    end
    nx = st;
    if (init)
      nx.crc = `DCW_CRC_INIT;
    else if (feed)
      nx.crc = c;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st.crc <= `DCW_CRC_INIT;
    else if (clk_en)
      st <= nx;
  end

  assign crc = st.crc;
endmodule : dcw_crc

// >>> core/dcw_watch.sv
// Purpose: Register file watchpoint compare
// Assumes: Read and write strobes are not high together
// Notes:   Break is a one-cycle pulse one edge after the access
`timescale 1ns/1ps
`include "dcw_defines.svh"
module dcw_watch
  import dcw_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic [7:0] wctl,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdat,
  input  wire dcw_rf_t    rf,
  output logic            brk
);
  dcw_wst_t st;
  dcw_wst_t nx;
  logic     amatch;
  logic     dmatch;

  assign amatch = (rf.addr == {wctl[3:0], waddr});
  assign dmatch = !wctl[`DCW_WATCH_DATA_MATCH_BIT] || (rf.data == wdat);

  always_comb
  begin
    nx = st;
    nx.brk = amatch && dmatch
           && ((rf.wr && wctl[`DCW_WPW_BIT])
           ||  (rf.rd && wctl[`DCW_WPR_BIT]));
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st <= '0;
    else if (clk_en)
      st <= nx;
  end

  assign brk = st.brk;

  AST_WR_BREAK: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && rf.wr && amatch && wctl[7] && !wctl[5]) |=> brk)
    else $error("enabled write watch did not break");
  AST_RD_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && rf.rd && !rf.wr && !wctl[6]) |=> !brk)
    else $error("read broke with read watch off");
  AST_DATA_MISS: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && wctl[5] && rf.data != wdat) |=> !brk)
    else $error("break without data match");
endmodule : dcw_watch

// >>> core/dcw_top.sv
// Purpose: Debug command engine with watchpoint registers on AXI4-Lite
// Assumes: Link bytes arrive as one-cycle strobes on ref_clk
// Notes:   Bytes arriving while a reply or memory access is busy are dropped
//
// Functional notes
// - Read memory 0DH: address hi, lo, count hi, lo; count bytes returned.
// - Count zero returns 65536 bytes; otherwise exactly the count.
// - Outside debug mode every read byte is FFH.
// - Command 0EH returns CRC-CCITT of program memory, upper byte first.
// - Outside debug mode the CRC answer is FFFFH.
// - CRC reply comes after about one clock per program byte.
// - Command 10H steps one instruction unless not debug or protected.
// - Command 11H takes an opcode byte and stuffs it, same gating.
// - Command 12H takes a whole 1-5 byte instruction for the CPU.
// - Gated execute swallows exactly one byte and runs nothing.
// - Read-only status bit shows read protection; neighbours read zero.
// - Control bit 7 enables break on matching register file write.
// - Control bit 6 enables break on matching register file read.
// - Under read protection bits 7, 6 and 5 stay zero.
// - Watchpoint control resets to all zero.
// - Bit 5 requires data equal to the watch data to break.
// - Control bits 3:0 are address bits 11:8; low byte separate.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "dcw_defines.svh"
module dcw_top
  import dcw_pkg::*;
#(
  parameter int unsigned PMEM_BYTES = 65536
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  output logic      [7:0]  tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic        debug_mode,
  input  wire logic        read_protect,
  output logic      [15:0] dmem_addr,
  output logic             dmem_req,
  input  wire logic        dmem_ack,
  input  wire logic [7:0]  dmem_rdata,
  output logic      [15:0] pmem_addr,
  output logic             pmem_req,
  input  wire logic        pmem_ack,
  input  wire logic [7:0]  pmem_rdata,
  output dcw_cpu_t         cpu_cmd,
  input  wire logic [2:0]  instr_len,
  input  wire dcw_rf_t     rf,
  output logic             debug_break,
  output logic             irq
);
  localparam logic [15:0] PMEM_LAST = 16'(PMEM_BYTES - 1);

  dcw_state_t  st;
  dcw_state_t  nx;
  logic [15:0] crc;
  logic        crc_init;
  logic        crc_feed;
  logic        brk;
  logic [2:0]  ev;
  logic        rd_clr;
  logic [15:0] cnt_word;

  dcw_crc u_crc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .init    (crc_init),
    .feed    (crc_feed),
    .byte_in (pmem_rdata),
    .crc     (crc)
  );

  dcw_watch u_watch (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .wctl    (st.wctl),
    .waddr   (st.waddr),
    .wdat    (st.wdat),
    .rf      (rf),
    .brk     (brk)
  );

  // Address and write data handshakes stall while the clock enable is low
  assign s_axi_awready = clk_en && !st.aw_got && !st.bvalid;
  assign s_axi_wready  = clk_en && !st.w_got && !st.bvalid;
  assign s_axi_arready = clk_en && !st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.berr ? `DCW_RESP_ERR : `DCW_RESP_OK;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rresp   = st.rerr ? `DCW_RESP_ERR : `DCW_RESP_OK;
  assign s_axi_rdata   = {24'h000000, st.rdata};

  assign tx_byte     = st.tx_byte;
  assign tx_valid    = st.tx_valid;
  assign dmem_addr   = st.addr;
  assign pmem_addr   = st.addr;
  assign dmem_req    = (st.fsm == S_RD_REQ);
  assign pmem_req    = (st.fsm == S_CRC_REQ);
  assign cpu_cmd     = st.cpu;
  assign debug_break = brk;
  assign irq         = |(st.irq & st.mask);

  assign crc_feed = clk_en && pmem_req && pmem_ack;
  assign cnt_word = {st.cnt[15:8], rx_byte};

  always_comb
  begin
    nx = st;
    nx.cpu.step  = 1'b0;
    nx.cpu.stuff = 1'b0;
    nx.cpu.valid = 1'b0;
    crc_init = 1'b0;
    rd_clr   = 1'b0;
    ev       = 3'h0;
    ev[`DCW_IRQ_BRK] = brk;

    // Register writes: address and data may come in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      nx.aw_got = 1'b1;
      nx.awa    = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nx.w_got = 1'b1;
      nx.wd    = s_axi_wdata[7:0];
      nx.wst   = s_axi_wstrb[0];
    end
    if (st.aw_got && st.w_got)
    begin
      nx.aw_got = 1'b0;
      nx.w_got  = 1'b0;
      nx.bvalid = 1'b1;
      nx.berr   = 1'b0;
      case (st.awa)
        `DCW_OFS_WCTL:
          if (st.wst)
            nx.wctl = st.wd;
        `DCW_OFS_WADDR:
          if (st.wst)
            nx.waddr = st.wd;
        `DCW_OFS_WDATA:
          if (st.wst)
            nx.wdat = st.wd;
        `DCW_OFS_MASK:
          if (st.wst)
            nx.mask = st.wd[2:0];
        `DCW_OFS_STATUS, `DCW_OFS_IRQ:
          ;
        default:
          nx.berr = 1'b1;
      endcase
    end
    if (st.bvalid && s_axi_bready)
      nx.bvalid = 1'b0;

    // Register reads
    if (s_axi_arvalid && s_axi_arready)
    begin
      nx.rvalid = 1'b1;
      nx.rerr   = 1'b0;
      case (s_axi_araddr)
        `DCW_OFS_WCTL:   nx.rdata = st.wctl;
        `DCW_OFS_WADDR:  nx.rdata = st.waddr;
        `DCW_OFS_WDATA:  nx.rdata = st.wdat;
        `DCW_OFS_STATUS: nx.rdata = {7'h00, read_protect};
        `DCW_OFS_MASK:   nx.rdata = {5'h00, st.mask};
        `DCW_OFS_IRQ:
        begin
          nx.rdata = {5'h00, st.irq};
          rd_clr   = 1'b1;
        end
        default:
        begin
          nx.rdata = 8'h00;
          nx.rerr  = 1'b1;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready)
      nx.rvalid = 1'b0;

    // Protection holds the break enables and data match at zero
    if (read_protect)
      nx.wctl = nx.wctl & `DCW_PROT_MASK;

    // Command engine
    unique case (st.fsm)
      S_IDLE:
        if (rx_valid)
        begin
          nx.dbg_ok = debug_mode;
          nx.run_ok = debug_mode && !read_protect;
          case (rx_byte)
            `DCW_CMD_RDMEM:
              nx.fsm = S_ADDR_HI;
            `DCW_CMD_CRC:
              if (debug_mode)
              begin
                crc_init = 1'b1;
                nx.addr  = 16'h0000;
                nx.fsm   = S_CRC_REQ;
              end
              else
              begin
                nx.tx_byte  = `DCW_BLANK_BYTE;
                nx.tx_valid = 1'b1;
                nx.fsm      = S_CRC_HI;
              end
            `DCW_CMD_STEP:
              if (debug_mode && !read_protect)
                nx.cpu.step = 1'b1;
              else
                ev[`DCW_IRQ_IGN] = 1'b1;
            `DCW_CMD_STUFF:
              nx.fsm = S_STUFF;
            `DCW_CMD_EXEC:
              nx.fsm = (debug_mode && !read_protect) ? S_EXEC_FIRST
                                                     : S_EXEC_DISCARD;
            default:
              ;
          endcase
        end
      S_ADDR_HI:
        if (rx_valid)
        begin
          nx.addr[15:8] = rx_byte;
          nx.fsm        = S_ADDR_LO;
        end
      S_ADDR_LO:
        if (rx_valid)
        begin
          nx.addr[7:0] = rx_byte;
          nx.fsm       = S_CNT_HI;
        end
      S_CNT_HI:
        if (rx_valid)
        begin
          nx.cnt = {1'b0, rx_byte, 8'h00};
          nx.fsm = S_CNT_LO;
        end
      S_CNT_LO:
        if (rx_valid)
        begin
          nx.cnt = (cnt_word == 16'h0000) ? `DCW_CNT_FULL
                                          : {1'b0, cnt_word};
          if (st.dbg_ok)
            nx.fsm = S_RD_REQ;
          else
          begin
            nx.tx_byte  = `DCW_BLANK_BYTE;
            nx.tx_valid = 1'b1;
            nx.fsm      = S_RD_SEND;
          end
        end
      S_RD_REQ:
        if (dmem_ack)
        begin
          nx.tx_byte  = dmem_rdata;
          nx.tx_valid = 1'b1;
          nx.fsm      = S_RD_SEND;
        end
      S_RD_SEND:
        if (tx_ready)
        begin
          nx.tx_valid = 1'b0;
          nx.cnt      = st.cnt - 17'h00001;
          nx.addr     = st.addr + 16'h0001;
          if (st.cnt == 17'h00001)
            nx.fsm = S_IDLE;
          else if (st.dbg_ok)
            nx.fsm = S_RD_REQ;
          else
            nx.tx_valid = 1'b1;
        end
      S_CRC_REQ:
        if (pmem_ack)
        begin
          nx.addr = st.addr + 16'h0001;
          if (st.addr == PMEM_LAST)
            nx.fsm = S_CRC_FIN;
        end
      S_CRC_FIN:
      begin
        nx.tx_byte  = crc[15:8];
        nx.tx_valid = 1'b1;
        ev[`DCW_IRQ_CRC] = 1'b1;
        nx.fsm      = S_CRC_HI;
      end
      S_CRC_HI:
        if (tx_ready)
        begin
          nx.tx_byte = st.dbg_ok ? crc[7:0] : `DCW_BLANK_BYTE;
          nx.fsm     = S_CRC_LO;
        end
      S_CRC_LO:
        if (tx_ready)
        begin
          nx.tx_valid = 1'b0;
          nx.fsm      = S_IDLE;
        end
      S_STUFF:
        if (rx_valid)
        begin
          if (st.run_ok)
          begin
            nx.cpu.stuff  = 1'b1;
            nx.cpu.byte_v = rx_byte;
          end
          else
            ev[`DCW_IRQ_IGN] = 1'b1;
          nx.fsm = S_IDLE;
        end
      S_EXEC_FIRST:
        if (rx_valid)
        begin
          nx.cpu.valid  = 1'b1;
          nx.cpu.byte_v = rx_byte;
          nx.fsm        = S_EXEC_LEN;
        end
      S_EXEC_LEN:
        if (instr_len > 3'h1)
        begin
          nx.left = 3'(instr_len - 3'h1);
          nx.fsm  = S_EXEC_REST;
        end
        else
          nx.fsm = S_IDLE;
      S_EXEC_REST:
        if (rx_valid)
        begin
          nx.cpu.valid  = 1'b1;
          nx.cpu.byte_v = rx_byte;
          nx.left       = st.left - 3'h1;
          if (st.left == 3'h1)
            nx.fsm = S_IDLE;
        end
      S_EXEC_DISCARD:
        if (rx_valid)
        begin
          ev[`DCW_IRQ_IGN] = 1'b1;
          nx.fsm = S_IDLE;
        end
    endcase

    // Events win over the clear-on-read
    nx.irq = (rd_clr ? 3'h0 : st.irq) | ev;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st      <= '0;
      st.wctl <= `DCW_WCTL_RST;
    end
    else if (clk_en)
      st <= nx;
  end

  AST_RD_BLANK: assert property (@(posedge ref_clk) disable iff (rst)
    (st.fsm == S_RD_SEND && !st.dbg_ok) |-> (tx_valid && tx_byte == 8'hFF))
    else $error("read outside debug mode not FFH");
  AST_CRC_BLANK: assert property (@(posedge ref_clk) disable iff (rst)
    (st.fsm inside {S_CRC_HI, S_CRC_LO} && !st.dbg_ok) |-> tx_byte == 8'hFF)
    else $error("CRC outside debug mode not FFFFH");
  AST_ZERO_COUNT: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && st.fsm == S_CNT_LO && rx_valid && st.cnt[15:8] == 8'h00
      && rx_byte == 8'h00) |=> st.cnt == 17'h10000)
    else $error("zero count not taken as 65536");
  AST_CRC_ORDER: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && st.fsm == S_CRC_HI && tx_ready && st.dbg_ok)
      |=> (tx_byte == crc[7:0] && st.fsm == S_CRC_LO))
    else $error("CRC low byte not second");
  AST_STEP_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && st.fsm == S_IDLE && rx_valid && rx_byte == 8'h10
      && !(debug_mode && !read_protect)) |=> !cpu_cmd.step)
    else $error("gated step reached the CPU");
  AST_DISCARD: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && st.fsm == S_EXEC_DISCARD && rx_valid)
      |=> (st.fsm == S_IDLE && !cpu_cmd.valid))
    else $error("discarded execute byte not dropped");
  AST_PROTECT: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && read_protect) |=> st.wctl[7:5] == 3'b000)
    else $error("break bits set under protection");
endmodule : dcw_top

// >>> bench/dcw_mem_model.sv
// Purpose: Memory and instruction decoder partner for the debug command block
// Assumes: One outstanding request per memory port
// Notes:   Slow mode adds three wait cycles before each acknowledge
`timescale 1ns/1ps
module dcw_mem_model
  import dcw_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic [15:0] dmem_addr,
  input  wire logic        dmem_req,
  output logic             dmem_ack,
  output logic      [7:0]  dmem_rdata,
  input  wire logic [15:0] pmem_addr,
  input  wire logic        pmem_req,
  output logic             pmem_ack,
  output logic      [7:0]  pmem_rdata,
  input  wire dcw_cpu_t    cpu_cmd,
  output logic      [2:0]  instr_len
);
  logic [1:0] dly;
  logic [7:0] dval;
  logic [7:0] pval;
  logic [2:0] lo;
  assign dval = dmem_addr[7:0] ^ dmem_addr[15:8] ^ 8'hA5;
  assign pval = pmem_addr[7:0] * 8'h07 + 8'h03;
  // Outside the ack cycle the lines carry the inverse, never stale data
  assign dmem_rdata = dmem_ack ? dval : ~dval;
  assign pmem_rdata = pmem_ack ? pval : ~pval;
  // Opcode low bits give the length 1..5; values 0, 6 and 7 give 1
  assign lo        = cpu_cmd.byte_v[2:0];
  assign instr_len = (lo == 3'h0 || lo > 3'h5) ? 3'h1 : lo;
  always_ff @(posedge ref_clk)
  begin
    dmem_ack <= 1'b0;
    pmem_ack <= 1'b0;
    if (rst)
      dly <= 2'h0;
    else if ((dmem_req || pmem_req) && !dmem_ack && !pmem_ack)
    begin
      if (!slow || dly == 2'h3)
      begin
        dly      <= 2'h0;
        dmem_ack <= dmem_req;
        pmem_ack <= pmem_req;
      end
      else
        dly <= dly + 2'h1;
    end
  end
endmodule : dcw_mem_model

// >>> bench/dcw_top_bench.sv
// Purpose: Self-checking bench for the debug command and watchpoint block
// Assumes: Program memory shortened to 16 bytes
// Notes:   Inputs change by non-blocking assignment after rising edges
`timescale 1ns/1ps
`include "dcw_defines.svh"
module dcw_top_bench
  import dcw_pkg::*;
;
  localparam int PMEM = 16;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [7:0]  rx_byte = 8'h00;
  logic        rx_valid = 1'b0;
  logic        tx_ready = 1'b1;
  logic        debug_mode = 1'b1;
  logic        read_protect = 1'b0;
  dcw_rf_t     rf = '0;
  logic        slow = 1'b0;
  logic        stall = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0]  tx_byte, dmem_rdata, pmem_rdata;
  logic [15:0] dmem_addr, pmem_addr;
  logic        tx_valid, dmem_req, dmem_ack, pmem_req, pmem_ack, debug_break, irq;
  logic [2:0]  instr_len;
  dcw_cpu_t    cpu_cmd;
  int          err_count = 0, n_compared = 0, cyc = 0;
  int          n_brk = 0, n_step = 0, n_stuff = 0, n_exec = 0, n_ff, i;
  logic [7:0]  rxq[$];

  dcw_top #(.PMEM_BYTES(PMEM)) u_dut (
    .ref_clk, .rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rx_byte, .rx_valid, .tx_byte, .tx_valid, .tx_ready, .debug_mode,
    .read_protect, .dmem_addr, .dmem_req, .dmem_ack, .dmem_rdata, .pmem_addr, .pmem_req,
    .pmem_ack, .pmem_rdata, .cpu_cmd, .instr_len, .rf, .debug_break, .irq);
  dcw_mem_model u_mem (.ref_clk, .rst, .slow, .dmem_addr, .dmem_req, .dmem_ack, .dmem_rdata,
    .pmem_addr, .pmem_req, .pmem_ack, .pmem_rdata, .cpu_cmd, .instr_len);

  always #50 ref_clk = ~ref_clk;

  // Pre-edge values: a byte moves, a pulse counts, at the edge that samples it
  always @(posedge ref_clk)
  begin
    cyc++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) rxq.push_back(tx_byte);
    if (debug_break === 1'b1) n_brk++;
    if (cpu_cmd.step === 1'b1) n_step++;
    if (cpu_cmd.stuff === 1'b1) n_stuff++;
    if (cpu_cmd.valid === 1'b1) n_exec++;
    tx_ready <= stall ? ~tx_ready : 1'b1;
    if (cyc == 90000)
    begin
      err_count++;
      $display("MISMATCH at %0t: run timed out", $time);
      final_report();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_t, w_t, b_t;
    logic [1:0] br;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // The write response ends this wait, or else the bench timeout
    forever
    begin
      @(negedge ref_clk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge ref_clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) break;
    end
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
    cmp({30'h0, br}, {30'h0, `DCW_RESP_OK}, "write response");
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ar_t, r_t;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(negedge ref_clk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) break;
    end
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
    cmp(d, {24'h0, e}, "read data");
    cmp({30'h0, r}, {30'h0, er}, "read response");
  endtask : rd_chk

  task automatic send(input logic [7:0] b);
    rx_byte <= b;
    rx_valid <= 1'b1;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : send

  task automatic rdmem(input logic [15:0] a, input logic [15:0] n);
    rxq.delete();
    send(`DCW_CMD_RDMEM);
    send(a[15:8]);
    send(a[7:0]);
    send(n[15:8]);
    send(n[7:0]);
  endtask : rdmem

  task automatic wait_q(input int n);
    for (int k = 0; k < 70000 && rxq.size() < n; k++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
  endtask : wait_q

  task automatic access(input logic r, input logic w, input logic [11:0] a, input logic [7:0] d);
    rf <= '{r, w, a, d};
    @(posedge ref_clk);
    rf <= '0;
    repeat (3) @(posedge ref_clk);
  endtask : access

  function automatic logic [15:0] crc_exp();
    logic [15:0] c;
    logic [7:0]  b;
    c = `DCW_CRC_INIT;
    for (int a = 0; a < PMEM; a++)
    begin
      b = a[7:0] * 8'h07 + 8'h03;
      c = c ^ {b, 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ `DCW_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc_exp

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(`DCW_OFS_WCTL, 8'h00, `DCW_RESP_OK);
    rd_chk(`DCW_OFS_STATUS, 8'h00, `DCW_RESP_OK);
    read_protect <= 1'b1;
    wr(`DCW_OFS_WCTL, 8'hFF);
    rd_chk(`DCW_OFS_STATUS, 8'h01, `DCW_RESP_OK);
    rd_chk(`DCW_OFS_WCTL, 8'h1F, `DCW_RESP_OK);
    read_protect <= 1'b0;
    wr(`DCW_OFS_WCTL, 8'hFF);
    rd_chk(`DCW_OFS_WCTL, 8'hFF, `DCW_RESP_OK);
    read_protect <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd_chk(`DCW_OFS_WCTL, 8'h1F, `DCW_RESP_OK);
    read_protect <= 1'b0;
    rd_chk(8'h18, 8'h00, `DCW_RESP_ERR);
    $display("test registers done");
    wr(`DCW_OFS_MASK, 8'h01);
    wr(`DCW_OFS_WADDR, 8'h45);
    wr(`DCW_OFS_WDATA, 8'h5A);
    wr(`DCW_OFS_WCTL, 8'h83);
    access(1'b0, 1'b1, 12'h345, 8'h11);
    access(1'b1, 1'b0, 12'h345, 8'h11);
    access(1'b0, 1'b1, 12'h245, 8'h11);
    cmp(n_brk, 1, "breaks on write");
    cmp({31'h0, irq}, 1, "irq level");
    rd_chk(`DCW_OFS_IRQ, 8'h01, `DCW_RESP_OK);
    cmp({31'h0, irq}, 0, "irq after clear");
    wr(`DCW_OFS_WCTL, 8'h43);
    access(1'b1, 1'b0, 12'h345, 8'h11);
    access(1'b0, 1'b1, 12'h345, 8'h11);
    cmp(n_brk, 2, "breaks on read");
    wr(`DCW_OFS_WCTL, 8'hA3);
    access(1'b0, 1'b1, 12'h345, 8'h11);
    access(1'b0, 1'b1, 12'h345, 8'h5A);
    wr(`DCW_OFS_WCTL, 8'h03);
    access(1'b0, 1'b1, 12'h345, 8'h5A);
    cmp(n_brk, 3, "data match breaks");
    rd_chk(`DCW_OFS_IRQ, 8'h01, `DCW_RESP_OK);
    wr(`DCW_OFS_MASK, 8'h07);
    $display("test watchpoint done");
    slow <= 1'b1;
    stall <= 1'b1;
    rdmem(16'h1234, 16'h0003);
    wait_q(3);
    cmp(rxq.size(), 3, "read count");
    for (i = 0; i < 3; i++) cmp(rxq[i], 8'h34 + i ^ 8'h12 ^ 8'hA5, "read byte");
    slow <= 1'b0;
    stall <= 1'b0;
    debug_mode <= 1'b0;
    rdmem(16'h0000, 16'h0000);
    wait_q(65536);
    n_ff = 0;
    foreach (rxq[k]) if (rxq[k] === `DCW_BLANK_BYTE) n_ff++;
    cmp(rxq.size(), 65536, "full count");
    cmp(n_ff, 65536, "blank bytes");
    $display("test memory read done");
    debug_mode <= 1'b1;
    rxq.delete();
    send(`DCW_CMD_CRC);
    wait_q(2);
    cmp({rxq[0], rxq[1]}, crc_exp(), "crc");
    debug_mode <= 1'b0;
    rxq.delete();
    send(`DCW_CMD_CRC);
    wait_q(2);
    cmp({rxq[0], rxq[1]}, 16'hFFFF, "blank crc");
    $display("test crc done");
    debug_mode <= 1'b1;
    send(`DCW_CMD_STEP);
    send(`DCW_CMD_STUFF);
    send(8'h9A);
    cmp(cpu_cmd.byte_v, 8'h9A, "stuffed opcode");
    send(`DCW_CMD_EXEC);
    send(8'h03);
    send(8'h21);
    send(8'h22);
    cmp(cpu_cmd.byte_v, 8'h22, "last execute byte");
    read_protect <= 1'b1;
    send(`DCW_CMD_STEP);
    send(`DCW_CMD_STUFF);
    send(8'h55);
    send(`DCW_CMD_EXEC);
    send(`DCW_CMD_RDMEM);
    cmp(n_step, 1, "steps");
    cmp(n_stuff, 1, "stuffs");
    cmp(n_exec, 3, "execute bytes");
    read_protect <= 1'b0;
    rxq.delete();
    send(`DCW_CMD_STEP);
    repeat (4) @(posedge ref_clk);
    cmp(n_step, 2, "step after swallow");
    cmp(rxq.size(), 0, "no stray reply");
    // A frozen block must not take a link byte
    clk_en <= 1'b0;
    send(`DCW_CMD_STEP);
    clk_en <= 1'b1;
    cmp(n_step, 2, "step while frozen");
    rd_chk(`DCW_OFS_IRQ, 8'h06, `DCW_RESP_OK);
    cmp({31'h0, irq}, 0, "irq cleared");
    $display("test cpu commands done");
    final_report();
  end
endmodule : dcw_top_bench
